/* File: bench/flash_query_geometry_rom_test.sv */
// Self-checking bench for the query database, 64 Mbit bottom and 128 Mbit top builds.
`timescale 1ns/1ps
module flash_query_geometry_rom_test;
  import query_rom_pkg::*;

  logic ref_clk;
  logic rst;
  query_req_t req;
  query_rsp_t rsp;
  query_rsp_t rsp_top;
  logic query_active;
  int mismatches;
  int n_checks;
  logic [15:0] d;
  logic [15:0] d2;
  logic v;
  logic v2;

  // Expected bytes for addresses 27h..76h
  localparam logic [7:0] ROWS [80] = '{
    8'h17, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02, 8'h07, 8'h00, 8'h20, 8'h00, 8'h7E, 8'h00,
    8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h52, 8'h49, 8'h31, 8'h33, 8'hE6,
    8'h03, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00, 8'h18, 8'hC0, 8'h01, 8'h80, 8'h00, 8'h03,
    8'h03, 8'h03, 8'h04, 8'h01, 8'h02, 8'h03, 8'h07, 8'h02, 8'h01, 8'h00, 8'h11, 8'h00,
    8'h00, 8'h02, 8'h07, 8'h00, 8'h20, 8'h00, 8'h64, 8'h00, 8'h01, 8'h03, 8'h06, 8'h00,
    8'h00, 8'h01, 8'h64, 8'h00, 8'h01, 8'h03, 8'h0F, 8'h00, 8'h11, 8'h00, 8'h00, 8'h01,
    8'h07, 8'h00, 8'h00, 8'h01, 8'h64, 8'h00, 8'h01, 8'h03};
  localparam logic [7:0] OUTSIDE [4] = '{8'h10, 8'h26, 8'h77, 8'hFF};
  // Same addresses on a 128 Mbit top-parameter build
  localparam logic [7:0] ROWS_TOP [80] = '{
    8'h18, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02, 8'hFE, 8'h00, 8'h00, 8'h01, 8'h07, 8'h00,
    8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h52, 8'h49, 8'h31, 8'h33, 8'hE6,
    8'h03, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00, 8'h18, 8'hC0, 8'h01, 8'h80, 8'h00, 8'h03,
    8'h03, 8'h03, 8'h04, 8'h01, 8'h02, 8'h03, 8'h07, 8'h02, 8'h1F, 8'h00, 8'h11, 8'h00,
    8'h00, 8'h01, 8'h07, 8'h00, 8'h00, 8'h01, 8'h64, 8'h00, 8'h01, 8'h03, 8'h01, 8'h00,
    8'h11, 8'h00, 8'h00, 8'h02, 8'h06, 8'h00, 8'h00, 8'h01, 8'h64, 8'h00, 8'h01, 8'h03,
    8'h07, 8'h00, 8'h20, 8'h00, 8'h64, 8'h00, 8'h01, 8'h03};

  flash_query_geometry_rom #(.DENSITY(DENS_64M), .TOP_PARAM(1'b0)) dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .query_active(query_active),
    .req(req),
    .rsp(rsp)
  );

  // Second build shares the host's reads; its data stands until the next read
  flash_query_geometry_rom #(.DENSITY(DENS_128M), .TOP_PARAM(1'b1)) dut_top (
    .ref_clk(ref_clk),
    .rst(rst),
    .query_active(query_active),
    .req(req),
    .rsp(rsp_top)
  );

  query_host host (
    .ref_clk(ref_clk),
    .rsp(rsp),
    .req(req),
    .query_active(query_active)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    n_checks++;
    if (seen !== expected) begin
      mismatches++;
      $display("BAD %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic results();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Roughly 280 cycles of traffic; allow about seven times that
  initial begin
    #50000;
    mismatches++;
    results();
  end

  initial begin
    logic [7:0] a;
    mismatches = 0;
    n_checks = 0;
    rst = 1'b1;
    repeat (7) @(posedge ref_clk);
    @(negedge ref_clk);
    check(rsp.data, 16'h0000);
    check({15'h0, rsp.valid}, 16'h0000);
    @(posedge ref_clk);
    rst <= 1'b0;
    host.mode(1'b1);
    // Table walk, one read per row
    for (int i = 0; i < 80; i++) begin
      a = 8'h27 + 8'(i);
      host.read(a, d, v, v2);
      check({15'h0, v}, 16'h0001);
      check({15'h0, v2}, 16'h0000);
      if (i < 18) begin
        check(d, {8'h00, ROWS[i]});
      end else if (i < 37) begin
        check(d, {8'h00, ROWS[i]});
      end else begin
        check(d, {8'h00, ROWS[i]});
      end
      check(rsp_top.data, {8'h00, ROWS_TOP[i]});
    end
    // Outside the tables nothing but zero comes back
    foreach (OUTSIDE[j]) begin
      host.read(OUTSIDE[j], d, v, v2);
      check(d, 16'h0000);
      check(rsp_top.data, 16'h0000);
      check({15'h0, v}, 16'h0001);
    end
    // Signature bytes read back to back
    host.pair(OFS_EXT_SIG, OFS_EXT_SIG + 8'h01, d, v, d2, v2);
    check(d, 16'h0050);
    check(d2, 16'h0052);
    // Back to back requests answer one per cycle
    host.pair(OFS_REGION_ONE, OFS_REGION_TWO, d, v, d2, v2);
    check(d, 16'h0007);
    check({15'h0, v}, 16'h0001);
    check(d2, 16'h007E);
    check({15'h0, v2}, 16'h0001);
    // Out of query mode a read is ignored and the old byte stands
    host.mode(1'b0);
    host.read(OFS_EXT_SIG, d, v, v2);
    check(d, 16'h007E);
    check({15'h0, v}, 16'h0000);
    check(rsp_top.data, 16'h0007);
    host.mode(1'b1);
    // Burst code 7 lands in the length field unchanged
    host.config_burst(OFS_BURST_FOUR);
    check({13'h0, host.burst_len}, 16'h0007);
    // Reset in mid-run clears the answer, reads resume at once
    @(posedge ref_clk);
    rst <= 1'b1;
    @(negedge ref_clk);
    check(rsp.data, 16'h0000);
    check({15'h0, rsp.valid}, 16'h0000);
    @(posedge ref_clk);
    rst <= 1'b0;
    host.read(OFS_SIZE_EXP, d, v, v2);
    check(d, 16'h0017);
    check(rsp_top.data, 16'h0018);
    check({15'h0, v}, 16'h0001);
    results();
  end
endmodule : flash_query_geometry_rom_test

/* File: bench/query_host.sv */
// Host model that issues query reads to the geometry database.
`timescale 1ns/1ps
module query_host (
  // Clock
  input wire logic ref_clk,
  // Device answer
  input wire query_rom_pkg::query_rsp_t rsp,
  // Request and query mode
  output query_rom_pkg::query_req_t req,
  output logic query_active
);
  import query_rom_pkg::*;

  logic [2:0] burst_len;

  initial begin
    req = '0;
    query_active = 1'b0;
    burst_len = 3'h0;
  end

  // Mode changes only just after a rising edge
  task automatic mode(input logic m);
    @(posedge ref_clk);
    query_active <= m;
  endtask : mode

  // Released address shows its inverse so a stale value never looks valid
  task automatic read(input logic [7:0] a, output logic [15:0] d, output logic v,
                      output logic v2);
    @(posedge ref_clk);
    req <= '{valid: 1'b1, addr: a};
    @(posedge ref_clk);
    req <= '{valid: 1'b0, addr: ~a};
    @(negedge ref_clk);
    d = rsp.data;
    v = rsp.valid;
    @(negedge ref_clk);
    v2 = rsp.valid;
  endtask : read

  // Two requests on consecutive edges
  task automatic pair(input logic [7:0] a, input logic [7:0] b, output logic [15:0] d1,
                      output logic v1, output logic [15:0] d2, output logic v2);
    @(posedge ref_clk);
    req <= '{valid: 1'b1, addr: a};
    @(posedge ref_clk);
    req <= '{valid: 1'b1, addr: b};
    @(negedge ref_clk);
    d1 = rsp.data;
    v1 = rsp.valid;
    @(posedge ref_clk);
    req <= '{valid: 1'b0, addr: ~b};
    @(negedge ref_clk);
    d2 = rsp.data;
    v2 = rsp.valid;
  endtask : pair

  // Burst code copied straight into the 3-bit length field
  task automatic config_burst(input logic [7:0] a);
    logic [15:0] d;
    logic v;
    logic v2;
    read(a, d, v, v2);
    burst_len = d[2:0];
  endtask : config_burst
endmodule : query_host

/* File: design/flash_query_geometry_rom.sv */
// Query database: geometry and extended tables as constant bytes.
`timescale 1ns/1ps
module flash_query_geometry_rom #(
  parameter logic [1:0] DENSITY = query_rom_pkg::DENS_32M,
  parameter logic TOP_PARAM = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Mode from command decoder
  input wire logic query_active,
  // Read path
  input wire query_rom_pkg::query_req_t req,
  output query_rom_pkg::query_rsp_t rsp
);
  import query_rom_pkg::*;

  // Density dependent bytes
  function automatic logic [7:0] size_exponent(input logic [1:0] dens);
    case (dens)
      DENS_64M: size_exponent = 8'h17;
      DENS_128M: size_exponent = 8'h18;
      default: size_exponent = 8'h16;
    endcase
  endfunction : size_exponent

  function automatic logic [7:0] main_block_count(input logic [1:0] dens);
    case (dens)
      DENS_64M: main_block_count = 8'h7E;
      DENS_128M: main_block_count = 8'hFE;
      default: main_block_count = 8'h3E;
    endcase
  endfunction : main_block_count

  function automatic logic [7:0] part_count(input logic [1:0] dens);
    case (dens)
      DENS_64M: part_count = 8'h0F;
      DENS_128M: part_count = 8'h1F;
      default: part_count = 8'h07;
    endcase
  endfunction : part_count

  // Bottom-only bytes pick the first argument
  function automatic logic [7:0] by_orient(input logic top, input logic [7:0] bot,
                                           input logic [7:0] tp);
    by_orient = top ? tp : bot;
  endfunction : by_orient

  logic [7:0] byte_d;
  logic [7:0] mbc;
  logic [7:0] pcnt;

  assign mbc = main_block_count(DENSITY);
  assign pcnt = part_count(DENSITY);

  // Address to byte; multi-byte fields keep the low byte at the low address
  always_comb begin // [RQ23] [RQ22]
    byte_d = VAL_ZERO;
    case (req.addr)
      OFS_SIZE_EXP: byte_d = size_exponent(DENSITY); // [RQ3]
      OFS_IF_WIDTH: byte_d = VAL_IF_X16;
      OFS_IF_WIDTH + 8'h01: byte_d = VAL_ZERO;
      OFS_WBUF_EXP: byte_d = VAL_ZERO;
      OFS_WBUF_EXP + 8'h01: byte_d = VAL_ZERO;
      OFS_ERASE_REGIONS: byte_d = VAL_ERASE_REGIONS;
      // Region one: count minus one, then size in 256 byte units
      OFS_REGION_ONE: byte_d = by_orient(TOP_PARAM, VAL_PARAM_BLOCKS, mbc); // [RQ1] [RQ2]
      OFS_REGION_ONE + 8'h01: byte_d = VAL_ZERO; // [RQ1]
      OFS_REGION_ONE + 8'h02: byte_d = by_orient(TOP_PARAM, VAL_PARAM_SIZE_LO,
                                                 VAL_MAIN_SIZE_LO); // [RQ1]
      OFS_REGION_ONE + 8'h03: byte_d = by_orient(TOP_PARAM, VAL_ZERO,
                                                 VAL_MAIN_SIZE_HI); // [RQ1]
      // Region two mirrors region one
      OFS_REGION_TWO: byte_d = by_orient(TOP_PARAM, mbc, VAL_PARAM_BLOCKS); // [RQ2]
      OFS_REGION_TWO + 8'h01: byte_d = VAL_ZERO; // [RQ1]
      OFS_REGION_TWO + 8'h02: byte_d = by_orient(TOP_PARAM, VAL_MAIN_SIZE_LO,
                                                 VAL_PARAM_SIZE_LO); // [RQ1]
      OFS_REGION_TWO + 8'h03: byte_d = by_orient(TOP_PARAM, VAL_MAIN_SIZE_HI,
                                                 VAL_ZERO); // [RQ1]
      OFS_REGION_RSVD, OFS_REGION_RSVD + 8'h01, OFS_REGION_RSVD + 8'h02,
      OFS_REGION_RSVD + 8'h03: byte_d = VAL_ZERO; // [RQ4]
      // Extended table header
      OFS_EXT_SIG: byte_d = VAL_SIG_0; // [RQ5]
      OFS_EXT_SIG + 8'h01: byte_d = VAL_SIG_1; // [RQ5]
      OFS_EXT_SIG + 8'h02: byte_d = VAL_SIG_2; // [RQ5]
      OFS_EXT_MAJOR: byte_d = VAL_EXT_MAJOR; // [RQ6]
      OFS_EXT_MINOR: byte_d = VAL_EXT_MINOR; // [RQ6]
      OFS_FEATURES: byte_d = VAL_FEAT_0; // [RQ7]
      OFS_FEATURES + 8'h01: byte_d = VAL_FEAT_1; // [RQ7]
      OFS_FEATURES + 8'h02, OFS_FEATURES + 8'h03: byte_d = VAL_ZERO; // [RQ7]
      OFS_SUSPEND_FN: byte_d = VAL_SUSPEND_FN; // [RQ8]
      OFS_BLK_MASK: byte_d = VAL_BLK_MASK; // [RQ9]
      OFS_BLK_MASK + 8'h01: byte_d = VAL_ZERO; // [RQ9]
      OFS_VLOGIC_OPT: byte_d = VAL_VLOGIC_OPT; // [RQ10]
      OFS_VPROG_OPT: byte_d = VAL_VPROG_OPT; // [RQ10]
      // Protection field
      OFS_PROT_COUNT: byte_d = VAL_PROT_COUNT; // [RQ11]
      OFS_PROT_ONE: byte_d = VAL_PROT_LOCK_LO; // [RQ11]
      OFS_PROT_ONE + 8'h01: byte_d = VAL_ZERO; // [RQ11]
      OFS_PROT_ONE + 8'h02, OFS_PROT_ONE + 8'h03: byte_d = VAL_PROT_EXP; // [RQ11]
      // Page and burst
      OFS_PAGE_CAP: byte_d = VAL_PAGE_CAP; // [RQ12]
      OFS_BURST_COUNT: byte_d = VAL_BURST_COUNT; // [RQ13]
      OFS_BURST_ONE: byte_d = VAL_BURST_4W; // [RQ13]
      OFS_BURST_TWO: byte_d = VAL_BURST_8W; // [RQ13]
      OFS_BURST_THREE: byte_d = VAL_BURST_16W; // [RQ13]
      // Continuous burst code fits the three length bits as is
      OFS_BURST_FOUR: byte_d = VAL_BURST_CONT; // [RQ13] [RQ14]
      // Partition region one; non-zero count so fields follow
      OFS_PART_REGIONS: byte_d = VAL_PART_REGIONS; // [RQ15]
      OFS_PART_COUNT: byte_d = by_orient(TOP_PARAM, VAL_ONE, pcnt); // [RQ16]
      OFS_PART_COUNT + 8'h01: byte_d = VAL_ZERO; // [RQ16]
      OFS_CONC_IN_PART: byte_d = VAL_CONC; // [RQ16]
      OFS_CONC_PROG: byte_d = VAL_ZERO; // [RQ16]
      OFS_CONC_ERASE: byte_d = VAL_ZERO; // [RQ16]
      // Non-zero, so this region is blocked rather than bulk erased
      OFS_PART_ERASE_RGN: byte_d = by_orient(TOP_PARAM, VAL_ERASE_REGIONS,
                                             VAL_ONE); // [RQ20]
      OFS_TYPE1_INFO: byte_d = VAL_PARAM_BLOCKS; // [RQ1]
      OFS_TYPE1_INFO + 8'h01: byte_d = VAL_ZERO; // [RQ1]
      OFS_TYPE1_INFO + 8'h02: byte_d = by_orient(TOP_PARAM, VAL_PARAM_SIZE_LO,
                                                 VAL_MAIN_SIZE_LO); // [RQ1]
      OFS_TYPE1_INFO + 8'h03: byte_d = by_orient(TOP_PARAM, VAL_ZERO,
                                                 VAL_MAIN_SIZE_HI); // [RQ1]
      OFS_TYPE1_ENDUR: byte_d = VAL_ENDUR_LO; // [RQ17]
      OFS_TYPE1_ENDUR + 8'h01: byte_d = VAL_ZERO; // [RQ17]
      OFS_TYPE1_CELL: byte_d = VAL_CELL; // [RQ17]
      OFS_TYPE1_CAP: byte_d = VAL_CAP; // [RQ18]
      // Bottom parts carry a second block type here; top parts begin region two
      OFS_TYPE2_INFO: byte_d = by_orient(TOP_PARAM, VAL_BOT_MAIN_IN_PART,
                                         VAL_ONE); // [RQ19]
      OFS_TYPE2_INFO + 8'h01: byte_d = VAL_ZERO; // [RQ19]
      OFS_TYPE2_INFO + 8'h02: byte_d = by_orient(TOP_PARAM, VAL_MAIN_SIZE_LO,
                                                 VAL_TOP_P2_BLOCKS); // [RQ19]
      OFS_TYPE2_INFO + 8'h03: byte_d = by_orient(TOP_PARAM, VAL_MAIN_SIZE_HI,
                                                 VAL_ZERO); // [RQ19]
      OFS_TYPE2_ENDUR: byte_d = by_orient(TOP_PARAM, VAL_ENDUR_LO, VAL_ZERO); // [RQ19]
      OFS_TYPE2_ENDUR + 8'h01: byte_d = by_orient(TOP_PARAM, VAL_ZERO,
                                                  VAL_ERASE_REGIONS); // [RQ19]
      OFS_TYPE2_CELL: byte_d = by_orient(TOP_PARAM, VAL_CELL,
                                         VAL_BOT_MAIN_IN_PART); // [RQ19] [RQ17]
      OFS_TYPE2_CAP: byte_d = by_orient(TOP_PARAM, VAL_CAP, VAL_ZERO); // [RQ19] [RQ18]
      // Remaining partition region descriptors
      OFS_TAIL_START: byte_d = by_orient(TOP_PARAM, pcnt, VAL_ZERO); // [RQ16]
      8'h6A: byte_d = by_orient(TOP_PARAM, VAL_ZERO, VAL_ONE);
      8'h6B: byte_d = by_orient(TOP_PARAM, VAL_CONC, VAL_ENDUR_LO);
      8'h6C: byte_d = VAL_ZERO;
      8'h6D: byte_d = by_orient(TOP_PARAM, VAL_ZERO, VAL_ONE);
      8'h6E: byte_d = by_orient(TOP_PARAM, VAL_ONE, VAL_CAP);
      8'h6F: byte_d = VAL_PARAM_BLOCKS;
      8'h70: byte_d = VAL_ZERO;
      8'h71: byte_d = by_orient(TOP_PARAM, VAL_ZERO, VAL_PARAM_SIZE_LO);
      8'h72: byte_d = by_orient(TOP_PARAM, VAL_ONE, VAL_ZERO);
      8'h73: byte_d = VAL_ENDUR_LO;
      8'h74: byte_d = VAL_ZERO;
      8'h75: byte_d = VAL_CELL;
      OFS_TAIL_END: byte_d = VAL_CAP;
      // Outside this table the byte reads zero
      default: byte_d = VAL_ZERO;
    endcase
  end

  // Answer one cycle after a query-mode read; data held until the next
  logic rsp_valid_q;
  logic [7:0] rsp_byte_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= req.valid && query_active; // [RQ23]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_byte_q <= VAL_ZERO;
    end else if (req.valid && query_active) begin
      rsp_byte_q <= byte_d;
    end
  end

  // Upper lane hard zero, so no stray bits on wide hosts
  assign rsp = '{valid: rsp_valid_q, data: {VAL_ZERO, rsp_byte_q}}; // [RQ21]

  chk_upper_lane_zero: assert property (@(posedge ref_clk) disable iff (rst) // [RQ21]
    rsp.valid |-> rsp.data[15:8] == 8'h00)
    else $error("upper data byte not zero");

  chk_answer_next_cycle: assert property (@(posedge ref_clk) disable iff (rst) // [RQ23]
    (req.valid && query_active) |=> rsp.valid ##1 (!rsp.valid || $past(req.valid)))
    else $error("query read not answered next cycle");

  chk_no_query_silent: assert property (@(posedge ref_clk) disable iff (rst) // [RQ23]
    !(req.valid && query_active) |=> !rsp.valid)
    else $error("answer without query read");

  chk_size_exponent: assert property (@(posedge ref_clk) disable iff (rst) // [RQ3]
    (req.valid && query_active && req.addr == 8'h27) |=>
      rsp.data[7:0] == (DENSITY == DENS_128M ? 8'h18 : DENSITY == DENS_64M ? 8'h17 : 8'h16))
    else $error("size exponent wrong");

  chk_region_one_count: assert property (@(posedge ref_clk) disable iff (rst) // [RQ2]
    (req.valid && query_active && req.addr == 8'h2D) |=>
      rsp.data[7:0] == (!TOP_PARAM ? 8'h07 : DENSITY == DENS_128M ? 8'hFE :
                        DENSITY == DENS_64M ? 8'h7E : 8'h3E))
    else $error("region one count wrong");

  chk_reserved_region: assert property (@(posedge ref_clk) disable iff (rst) // [RQ4]
    (req.valid && query_active && req.addr >= 8'h35 && req.addr <= 8'h38) |=>
      rsp.data == 16'h0000)
    else $error("reserved region byte not zero");

  chk_signature_bytes: assert property (@(posedge ref_clk) disable iff (rst) // [RQ5]
    (req.valid && query_active && req.addr == 8'h39) ##1
      (req.valid && query_active && req.addr == 8'h3A) |=>
      rsp.data[7:0] == 8'h52 && $past(rsp.data[7:0]) == 8'h50)
    else $error("extended signature wrong");

  chk_version_digits: assert property (@(posedge ref_clk) disable iff (rst) // [RQ6]
    (req.valid && query_active && req.addr == 8'h3D) |=> rsp.data[7:0] == 8'h33)
    else $error("minor version wrong");

  chk_feature_low: assert property (@(posedge ref_clk) disable iff (rst) // [RQ7]
    (req.valid && query_active && req.addr == 8'h3E) |=> rsp.data[7:0] == 8'hE6)
    else $error("feature word low byte wrong");

  chk_burst_continuous: assert property (@(posedge ref_clk) disable iff (rst) // [RQ14]
    (req.valid && query_active && req.addr == 8'h51) |=> rsp.data[2:0] == 3'h7)
    else $error("continuous burst code wrong");

  chk_protection_lock: assert property (@(posedge ref_clk) disable iff (rst) // [RQ11]
    (req.valid && query_active && req.addr == 8'h48) |=> rsp.data[7:0] == 8'h80)
    else $error("protection lock address wrong");

endmodule : flash_query_geometry_rom

/* File: design/query_rom_pkg.sv */
// Constants, types and address map for the query database block.
// How it works
// [RQ1] Erase region descriptor: low half is block count minus one, high half is size/256.
// [RQ2] Region one count reads 07 bottom; 3E/7E/FE top by density; region two mirrors.
// [RQ3] Size exponent byte reads 16, 17 or 18 for 32, 64, 128 Mbit.
// [RQ4] The reserved future region descriptor reads four zero bytes always.
// [RQ5] Extended table starts at 39h with signature bytes 50, 52, 49.
// [RQ6] Extended table major and minor versions read ASCII 31 and 33.
// [RQ7] Optional feature word reads E6 03 00 00.
// [RQ8] After-suspend functions byte reads 01: program allowed during erase suspend.
// [RQ9] Block status mask reads 03 00: lock and lock-down bits active.
// [RQ10] Optimum voltages: logic supply 18 in BCD, program supply C0 hex volts.
// [RQ11] One protection field: lock byte at 80h, exponents 3 and 3.
// [RQ12] Page read capability byte reads 03, an eight byte page.
// [RQ13] Four burst configuration fields reading 01, 02, 03 and 07.
// [RQ14] Burst value 07 means continuous; value copies straight into burst length bits.
// [RQ15] Partition region count byte; zero would mean single partition, no fields follow.
// [RQ16] Per partition region: two byte partition count, three concurrency bytes.
// [RQ17] Each block type: endurance in thousands, then bits per cell and ECC flag.
// [RQ18] Each block type: capability byte with page, sync read, sync write bits.
// [RQ19] Second block type of partition region one exists only on bottom parts.
// [RQ20] Zero erase region count inside a partition region means bulk erase.
// [RQ21] Query byte on low data lines; upper data lines read zero.
// [RQ22] Multi-byte fields little-endian, least significant byte at lowest address.
// [RQ23] In query mode each address maps to a build-time constant byte.
package query_rom_pkg;

  // Build-time density codes; orientation comes from TOP_PARAM
  localparam logic [1:0] DENS_32M = 2'h0;
  localparam logic [1:0] DENS_64M = 2'h1;
  localparam logic [1:0] DENS_128M = 2'h2;

  // Register map, word addresses
  localparam logic [7:0] OFS_SIZE_EXP = 8'h27;
  localparam logic [7:0] OFS_IF_WIDTH = 8'h28;
  localparam logic [7:0] OFS_WBUF_EXP = 8'h2A;
  localparam logic [7:0] OFS_ERASE_REGIONS = 8'h2C;
  localparam logic [7:0] OFS_REGION_ONE = 8'h2D;
  localparam logic [7:0] OFS_REGION_TWO = 8'h31;
  localparam logic [7:0] OFS_REGION_RSVD = 8'h35;
  localparam logic [7:0] OFS_EXT_SIG = 8'h39;
  localparam logic [7:0] OFS_EXT_MAJOR = 8'h3C;
  localparam logic [7:0] OFS_EXT_MINOR = 8'h3D;
  localparam logic [7:0] OFS_FEATURES = 8'h3E;
  localparam logic [7:0] OFS_SUSPEND_FN = 8'h42;
  localparam logic [7:0] OFS_BLK_MASK = 8'h43;
  localparam logic [7:0] OFS_VLOGIC_OPT = 8'h45;
  localparam logic [7:0] OFS_VPROG_OPT = 8'h46;
  localparam logic [7:0] OFS_PROT_COUNT = 8'h47;
  localparam logic [7:0] OFS_PROT_ONE = 8'h48;
  localparam logic [7:0] OFS_PAGE_CAP = 8'h4C;
  localparam logic [7:0] OFS_BURST_COUNT = 8'h4D;
  localparam logic [7:0] OFS_BURST_ONE = 8'h4E;
  localparam logic [7:0] OFS_BURST_TWO = 8'h4F;
  localparam logic [7:0] OFS_BURST_THREE = 8'h50;
  localparam logic [7:0] OFS_BURST_FOUR = 8'h51;
  localparam logic [7:0] OFS_PART_REGIONS = 8'h52;
  localparam logic [7:0] OFS_PART_COUNT = 8'h53;
  localparam logic [7:0] OFS_CONC_IN_PART = 8'h55;
  localparam logic [7:0] OFS_CONC_PROG = 8'h56;
  localparam logic [7:0] OFS_CONC_ERASE = 8'h57;
  localparam logic [7:0] OFS_PART_ERASE_RGN = 8'h58;
  localparam logic [7:0] OFS_TYPE1_INFO = 8'h59;
  localparam logic [7:0] OFS_TYPE1_ENDUR = 8'h5D;
  localparam logic [7:0] OFS_TYPE1_CELL = 8'h5F;
  localparam logic [7:0] OFS_TYPE1_CAP = 8'h60;
  localparam logic [7:0] OFS_TYPE2_INFO = 8'h61;
  localparam logic [7:0] OFS_TYPE2_ENDUR = 8'h65;
  localparam logic [7:0] OFS_TYPE2_CELL = 8'h67;
  localparam logic [7:0] OFS_TYPE2_CAP = 8'h68;
  // Second partition region starts here on bottom parts; on top parts it continues here
  localparam logic [7:0] OFS_TAIL_START = 8'h69;
  localparam logic [7:0] OFS_TAIL_END = 8'h76;

  // Fixed values
  localparam logic [7:0] VAL_ZERO = 8'h00;
  localparam logic [7:0] VAL_ONE = 8'h01;
  localparam logic [7:0] VAL_IF_X16 = 8'h01;
  localparam logic [7:0] VAL_ERASE_REGIONS = 8'h02;
  localparam logic [7:0] VAL_SIG_0 = 8'h50;
  localparam logic [7:0] VAL_SIG_1 = 8'h52;
  localparam logic [7:0] VAL_SIG_2 = 8'h49;
  localparam logic [7:0] VAL_EXT_MAJOR = 8'h31;
  localparam logic [7:0] VAL_EXT_MINOR = 8'h33;
  localparam logic [7:0] VAL_FEAT_0 = 8'hE6;
  localparam logic [7:0] VAL_FEAT_1 = 8'h03;
  localparam logic [7:0] VAL_SUSPEND_FN = 8'h01;
  localparam logic [7:0] VAL_BLK_MASK = 8'h03;
  localparam logic [7:0] VAL_VLOGIC_OPT = 8'h18;
  localparam logic [7:0] VAL_VPROG_OPT = 8'hC0;
  localparam logic [7:0] VAL_PROT_COUNT = 8'h01;
  localparam logic [7:0] VAL_PROT_LOCK_LO = 8'h80;
  localparam logic [7:0] VAL_PROT_EXP = 8'h03;
  localparam logic [7:0] VAL_PAGE_CAP = 8'h03;
  localparam logic [7:0] VAL_BURST_COUNT = 8'h04;
  localparam logic [7:0] VAL_BURST_4W = 8'h01;
  localparam logic [7:0] VAL_BURST_8W = 8'h02;
  localparam logic [7:0] VAL_BURST_16W = 8'h03;
  localparam logic [7:0] VAL_BURST_CONT = 8'h07;
  localparam logic [7:0] VAL_PART_REGIONS = 8'h02;
  localparam logic [7:0] VAL_CONC = 8'h11;
  localparam logic [7:0] VAL_PARAM_BLOCKS = 8'h07;
  localparam logic [7:0] VAL_MAIN_SIZE_LO = 8'h00;
  localparam logic [7:0] VAL_MAIN_SIZE_HI = 8'h01;
  localparam logic [7:0] VAL_PARAM_SIZE_LO = 8'h20;
  localparam logic [7:0] VAL_ENDUR_LO = 8'h64;
  localparam logic [7:0] VAL_CELL = 8'h01;
  localparam logic [7:0] VAL_CAP = 8'h03;
  localparam logic [7:0] VAL_BOT_MAIN_IN_PART = 8'h06;
  localparam logic [7:0] VAL_TOP_P2_BLOCKS = 8'h11;
  localparam logic [7:0] VAL_TOP_PART_REGIONS = 8'h01;

  // Host read request and device answer
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } query_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } query_rsp_t;

endpackage : query_rom_pkg
